// ---- sioflg_pkg.sv ----
// Shared constants for the starter control-input and status-relay logic
package sioflg_pkg;
  // Input function codes
  localparam logic [3:0] FN_NONE      = 4'h0;
  localparam logic [3:0] FN_ALARM_INH = 4'h7;
  localparam logic [3:0] FN_EXT_TRIP  = 4'h8;
  localparam logic [3:0] FN_EXT_WARN  = 4'h9;
  localparam logic [3:0] FN_OL_INH    = 4'hA;
  localparam logic [3:0] FN_ANALOG    = 4'hB;
  // Reset values of the input function codes
  localparam logic [3:0] FN_RST0 = 4'h1;
  localparam logic [3:0] FN_RST1 = 4'h3;
  localparam logic [3:0] FN_RST2 = 4'h4;
  localparam logic [3:0] FN_RST3 = 4'h5;
  // Index of the only input that may take the analog function
  localparam int ANALOG_IDX = 3;
  // Relay option codes
  localparam logic [3:0] RO_OFF      = 4'h0;
  localparam logic [3:0] RO_FAULT    = 4'h1;
  localparam logic [3:0] RO_FAULT_N  = 4'h2;
  localparam logic [3:0] RO_BYP      = 4'h3;
  localparam logic [3:0] RO_BYP_N    = 4'h4;
  localparam logic [3:0] RO_ENER     = 4'h5;
  localparam logic [3:0] RO_ENER_N   = 4'h6;
  localparam logic [3:0] RO_WARN     = 4'h7;
  localparam logic [3:0] RO_WARN_N   = 4'h8;
  localparam logic [3:0] RO_CUSTOM   = 4'h9;
  localparam logic [3:0] RO_CUSTOM_N = 4'hA;
  // Analog thresholds action codes
  localparam logic [1:0] ACT_OFF  = 2'h0;
  localparam logic [1:0] ACT_TRIP = 2'h1;
  localparam logic [1:0] ACT_WARN = 2'h2;
  // Analog range select: zero-based or 4 mA based
  localparam logic RANGE_0_20 = 1'b0;
  localparam logic RANGE_4_20 = 1'b1;
  // Analog code full scale (12-bit code for 20 mA) and 4 mA offset
  localparam logic [11:0] ADC_FULL  = 12'hFFF;
  localparam logic [11:0] ADC_4MA   = 12'h333;
  localparam logic [6:0]  PCT_FULL  = 7'h64;
  // Input filter time and its cycle count at 125 MHz
  localparam int CLK_MHZ      = 125;
  localparam int FILT_TIME_US = 10;
  localparam int FILT_CYCLES  = FILT_TIME_US * CLK_MHZ;
  // Custom list entries
  localparam int CUST_SLOTS = 3;
endpackage

// ---- sioflg_filter.sv ----
// Synchroniser and debounce filter for one control input
`timescale 1ns/10ps
module sioflg_filter #(
  parameter int CYCLES = sioflg_pkg::FILT_CYCLES
) (
  input  wire logic mclk_in,
  input  wire logic arst_n_in,
  input  wire logic raw_in,
  output logic      clean_out
);
  localparam int CW = $clog2(CYCLES + 1);

  logic          sync1;       // First synchroniser stage
  logic          sync2;       // Second synchroniser stage
  logic [CW-1:0] cnt;         // Stable-time counter
  logic          clean;       // Filtered level
  logic [CW-1:0] next_cnt;
  logic          next_clean;

  // Level must differ from the output for CYCLES clocks before it is taken
  always_comb begin
    next_cnt   = '0;
    next_clean = clean;
    if (sync2 != clean) begin
      if (cnt == CW'(CYCLES - 1)) begin
        next_clean = sync2;
      end else begin
        next_cnt = cnt + CW'(1);
      end
    end
  end

  // Register the synchroniser and filter
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      cnt   <= '0;
      clean <= 1'b0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      cnt   <= next_cnt;
      clean <= next_clean;
    end
  end

  assign clean_out = clean;
endmodule

// ---- sioflg_core.sv ----
// Control-input function decode and status-relay drive for the soft starter
`timescale 1ns/10ps
module sioflg_core #(
  parameter int N_IN    = 4,
  parameter int N_RLY   = 2,
  parameter int CODE_W  = 6,
  parameter int FILT_CY = sioflg_pkg::FILT_CYCLES
) (
  input  wire logic                         mclk_in,
  input  wire logic                         arst_n_in,
  input  wire logic [N_IN-1:0]              ctl_in,
  input  wire logic [N_IN*4-1:0]            in_func_in,
  input  wire logic [11:0]                  analog_code_in,
  input  wire logic                         analog_range_in,
  input  wire logic [6:0]                   analog_high_in,
  input  wire logic [6:0]                   analog_low_in,
  input  wire logic [1:0]                   analog_action_in,
  input  wire logic                         start_cmd_in,
  input  wire logic                         ramp_active_in,
  input  wire logic                         running_in,
  input  wire logic                         soft_stop_in,
  input  wire logic                         pump_stop_in,
  input  wire logic                         bypass_closed_in,
  input  wire logic                         other_fault_in,
  input  wire logic                         other_warn_in,
  input  wire logic [N_RLY*4-1:0]           relay_opt_in,
  input  wire logic [N_RLY*3*CODE_W-1:0]    custom_code_in,
  input  wire logic [N_RLY*3-1:0]           custom_is_fault_in,
  input  wire logic [(1<<CODE_W)-1:0]       fault_active_in,
  input  wire logic [(1<<CODE_W)-1:0]       warn_active_in,
  input  wire logic [(1<<CODE_W)-1:0]       prot_enable_in,
  output logic                              alarm_inhibit_out,
  output logic                              ext_trip_out,
  output logic                              ext_warn_out,
  output logic                              motor_power_kill_out,
  output logic                              overload_enable_out,
  output logic                              analog_trip_out,
  output logic                              analog_warn_out,
  output logic [6:0]                        analog_pct_out,
  output logic                              fault_any_out,
  output logic                              warn_any_out,
  output logic [N_RLY-1:0]                  relay_out,
  output logic [N_RLY-1:0]                  custom_is_fault_hit_out
);

  // Timing overview: a control input reaches its decoded flag FILT_CY + 3 clocks
  // after it settles: two synchroniser stages, the stable-time count, then the
  // decode register. Relay, analog and overload outputs follow their own inputs
  // by one clock. Function codes and relay options are plain levels; a change
  // to either takes effect at the next clock, so the host may reprogram them
  // at run time without a separate load strobe.

  logic [N_IN-1:0]  clean;           // Filtered input levels
  logic             start_d;         // Start command seen last cycle
  logic             ol_inh;          // Overload inhibited for this start
  logic             alarm_inhibit;   // Alarm-inhibit state
  logic             ext_trip;        // External trip present
  logic             ext_warn;        // External warning present
  logic             an_trip;         // Analog threshold trip
  logic             an_warn;         // Analog threshold warning
  logic [6:0]       pct;             // Scaled analog value
  logic [N_RLY-1:0] relay;           // Relay drives
  logic [N_RLY-1:0] cfhit;           // Custom hit reported as a fault
  logic             next_start_d;
  logic             next_ol_inh;
  logic             next_alarm_inhibit;
  logic             next_ext_trip;
  logic             next_ext_warn;
  logic             next_an_trip;
  logic             next_an_warn;
  logic [6:0]       next_pct;
  logic [N_RLY-1:0] next_relay;
  logic [N_RLY-1:0] next_cfhit;
  logic             any_fault;       // Combined fault indication
  logic             any_warn;        // Combined warning indication
  logic             energized;       // Motor being driven

  // Every input slot carries the same 4-bit code field, so one helper serves
  // all decode sites; the caller restricts which slots may select analog.
  // Return whether input idx holds function fn (analog only valid on the last)
  function automatic logic fn_is(input logic [N_IN*4-1:0] f, input int idx,
                                 input logic [3:0] fn);
    fn_is = (f[idx*4 +: 4] == fn);
  endfunction

  // Scale a current code to 0..100 percent for the selected range
  // Codes below the 4 mA point clamp to zero rather than wrapping, so a broken
  // loop in the 4-20 mA range reads as 0 percent, below any nonzero low limit.
  // The quotient truncates; a reading just above the high limit stays inside it.
  // The product fits 20 bits: the largest code times 100 stays below 2^20.
  function automatic logic [6:0] scale_pct(input logic [11:0] code, input logic rng);
    logic [11:0] base;
    logic [11:0] span;
    logic [11:0] val;
    logic [19:0] prod;
    base = (rng == sioflg_pkg::RANGE_4_20) ? sioflg_pkg::ADC_4MA : 12'h000;
    span = sioflg_pkg::ADC_FULL - base;
    val  = (code > base) ? (code - base) : 12'h000;
    prod = 20'(val) * 20'(sioflg_pkg::PCT_FULL);
    scale_pct = 7'(prod / 20'(span));
  endfunction

  // Field wiring picks up contact bounce and shock; without the filter a single
  // noisy clock on a maintained trip input would remove motor power.
  // Filter every control input before decoding
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_filt
      sioflg_filter #(.CYCLES(FILT_CY)) u_filt (
        .mclk_in   (mclk_in),
        .arst_n_in (arst_n_in),
        .raw_in    (ctl_in[gi]),
        .clean_out (clean[gi])
      );
    end
  endgenerate

  // Decode input functions, analog scaling and overload inhibit
  // Alarm-inhibit, trip and warning inputs act on loss of the signal, so a cut
  // wire fails towards the protective state. Several inputs sharing one code
  // are ORed: any one of them losing its signal is enough.
  // All flags but the overload inhibit are recomputed every clock; only that one is latched, so each
  // other flag clears as soon as its filtered input returns.
  // Codes 0 to 6 are handled elsewhere and produce nothing here.
  always_comb begin
    next_alarm_inhibit = 1'b0;
    next_ext_trip      = 1'b0;
    next_ext_warn      = 1'b0;
    next_an_trip       = 1'b0;
    next_an_warn       = 1'b0;
    next_pct           = 7'h00;
    next_start_d       = start_cmd_in;
    next_ol_inh        = ol_inh;
    for (int i = 0; i < N_IN; i++) begin
      if (fn_is(in_func_in, i, sioflg_pkg::FN_ALARM_INH) && !clean[i]) begin
        next_alarm_inhibit = 1'b1;
      end
      if (fn_is(in_func_in, i, sioflg_pkg::FN_EXT_TRIP) && !clean[i]) begin
        next_ext_trip = 1'b1;
      end
      if (fn_is(in_func_in, i, sioflg_pkg::FN_EXT_WARN) && !clean[i]) begin
        next_ext_warn = 1'b1;
      end
      // Inhibit is latched on the start edge if the input was already high
      // Raising the input during a ramp already under way has no effect, so an
      // overload that starts mid-ramp is never masked after the fact.
      if (fn_is(in_func_in, i, sioflg_pkg::FN_OL_INH) && clean[i] &&
          start_cmd_in && !start_d) begin
        next_ol_inh = 1'b1;
      end
    end
    // Bypass closing ends the inhibit for this start
    // It also wins over a start edge in the same clock, since a motor already
    // at speed has no ramp left to protect.
    if (bypass_closed_in) begin
      next_ol_inh = 1'b0;
    end
    // Analog only decoded on the fourth input
    // Code 11 on any other slot is ignored and leaves the percent output at zero.
    // Out of range means strictly above the high or strictly below the low limit.
    if (fn_is(in_func_in, sioflg_pkg::ANALOG_IDX, sioflg_pkg::FN_ANALOG)) begin
      next_pct = scale_pct(analog_code_in, analog_range_in);
      if (next_pct > analog_high_in || next_pct < analog_low_in) begin
        case (analog_action_in)
          sioflg_pkg::ACT_TRIP: begin
            next_an_trip = 1'b1;
          end
          sioflg_pkg::ACT_WARN: begin
            next_an_warn = 1'b1;
          end
          default: begin
            next_an_trip = 1'b0;
          end
        endcase
      end
    end
  end

  // Status summaries feeding the relays
  // These stay combinational so a relay tracks its cause with one register
  // stage only; the same sums are exported for the host.
  // Motor energized covers ramp, run at top of ramp, soft stop and pump stop.
  assign any_fault = ext_trip || an_trip || other_fault_in;
  assign any_warn  = ext_warn || an_warn || other_warn_in;
  assign energized = ramp_active_in || running_in || soft_stop_in || pump_stop_in;

  // Relay option decode
  // Each listed slot is checked against the active fault or warning vector.
  // A listed fault counts only while its protection is enabled, so a disabled
  // protection never actuates the relay. Fault hits are reported separately
  // so the host can give them priority over warning hits; the relay itself
  // responds to either kind. Unused option codes above 10 hold the relay off.
  always_comb begin
    logic       hit_f;
    logic       hit_w;
    logic [3:0] opt;
    logic [CODE_W-1:0] cd;
    hit_f      = 1'b0;
    hit_w      = 1'b0;
    opt        = 4'h0;
    cd         = '0;
    next_relay = '0;
    next_cfhit = '0;
    for (int r = 0; r < N_RLY; r++) begin
      hit_f = 1'b0;
      hit_w = 1'b0;
      opt   = relay_opt_in[r*4 +: 4];
      for (int s = 0; s < sioflg_pkg::CUST_SLOTS; s++) begin
        cd = custom_code_in[(r*3+s)*CODE_W +: CODE_W];
        if (custom_is_fault_in[r*3+s]) begin
          if (fault_active_in[cd] && prot_enable_in[cd]) begin
            hit_f = 1'b1;
          end
        end else if (warn_active_in[cd]) begin
          hit_w = 1'b1;
        end
      end
      next_cfhit[r] = hit_f;
      // Odd codes follow their condition, the next even code inverts it
      case (opt)
        sioflg_pkg::RO_OFF:      next_relay[r] = 1'b0;
        sioflg_pkg::RO_FAULT:    next_relay[r] = any_fault;
        sioflg_pkg::RO_FAULT_N:  next_relay[r] = !any_fault;
        sioflg_pkg::RO_BYP:      next_relay[r] = bypass_closed_in;
        sioflg_pkg::RO_BYP_N:    next_relay[r] = !bypass_closed_in;
        sioflg_pkg::RO_ENER:     next_relay[r] = energized;
        sioflg_pkg::RO_ENER_N:   next_relay[r] = !energized;
        sioflg_pkg::RO_WARN:     next_relay[r] = any_warn;
        sioflg_pkg::RO_WARN_N:   next_relay[r] = !any_warn;
        sioflg_pkg::RO_CUSTOM:   next_relay[r] = hit_f || hit_w;
        sioflg_pkg::RO_CUSTOM_N: next_relay[r] = !(hit_f || hit_w);
        default:                 next_relay[r] = 1'b0;
      endcase
    end
  end

  // Register decoded state
  // Reset leaves every flag clear and overload protection enabled, which is
  // the safe state until the inputs have been filtered.
  // Decode and relay paths share one register bank so outputs move together.
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      start_d       <= 1'b0;
      ol_inh        <= 1'b0;
      alarm_inhibit <= 1'b0;
      ext_trip      <= 1'b0;
      ext_warn      <= 1'b0;
      an_trip       <= 1'b0;
      an_warn       <= 1'b0;
      pct           <= 7'h00;
      relay         <= '0;
      cfhit         <= '0;
    end else begin
      start_d       <= next_start_d;
      ol_inh        <= next_ol_inh;
      alarm_inhibit <= next_alarm_inhibit;
      ext_trip      <= next_ext_trip;
      ext_warn      <= next_ext_warn;
      an_trip       <= next_an_trip;
      an_warn       <= next_an_warn;
      pct           <= next_pct;
      relay         <= next_relay;
      cfhit         <= next_cfhit;
    end
  end

  // Outputs
  // Power removal follows the external trip directly; no ramp is waited for,
  // even when soft stop or pump stop is selected.
  // The overload inhibit flag is stored active high and inverted here for the enable port.
  assign alarm_inhibit_out       = alarm_inhibit;
  assign ext_trip_out            = ext_trip;
  assign ext_warn_out            = ext_warn;
  assign motor_power_kill_out    = ext_trip;
  assign overload_enable_out     = !ol_inh;
  assign analog_trip_out         = an_trip;
  assign analog_warn_out         = an_warn;
  assign analog_pct_out          = pct;
  assign fault_any_out           = any_fault;
  assign warn_any_out            = any_warn;
  assign relay_out               = relay;
  assign custom_is_fault_hit_out = cfhit;
endmodule

// ---- sioflg_asserts.sv ----
// Concurrent checks on the control-input and relay block ports
`timescale 1ns/10ps
module sioflg_asserts (
  input wire logic        mclk_in,
  input wire logic        arst_n_in,
  input wire logic        bypass_closed_in,
  input wire logic        ramp_active_in,
  input wire logic        running_in,
  input wire logic        soft_stop_in,
  input wire logic        pump_stop_in,
  input wire logic [7:0]  relay_opt_in,
  input wire logic [15:0] in_func_in,
  input wire logic [11:0] analog_code_in,
  input wire logic [1:0]  analog_action_in,
  input wire logic        ext_trip_out,
  input wire logic        ext_warn_out,
  input wire logic        motor_power_kill_out,
  input wire logic        overload_enable_out,
  input wire logic        analog_trip_out,
  input wire logic        analog_warn_out,
  input wire logic [6:0]  analog_pct_out,
  input wire logic        fault_any_out,
  input wire logic        warn_any_out,
  input wire logic [1:0]  relay_out
);
  // Motor is energized in any ramp, run or stop phase
  wire ener = ramp_active_in | running_in | soft_stop_in | pump_stop_in;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  // Bypass closing after having been open
  sequence s_byp_close;
    !bypass_closed_in ##1 bypass_closed_in;
  endsequence
  // Relay 0 set to follow the energized state
  sequence s_ener_sel;
    relay_opt_in[3:0] == sioflg_pkg::RO_ENER;
  endsequence
  a_trip_kills_power: assert property (ext_trip_out |-> motor_power_kill_out)
    else $error("Trip without power removal");
  a_trip_is_fault: assert property (ext_trip_out |-> fault_any_out)
    else $error("Trip not seen as fault");
  a_warn_is_warn: assert property (ext_warn_out |-> warn_any_out)
    else $error("Warning not reported");
  a_ol_reenable: assert property (s_byp_close |=> overload_enable_out)
    else $error("Overload not re-enabled on bypass");
  a_relay_off: assert property (relay_opt_in[3:0] == sioflg_pkg::RO_OFF |=> !relay_out[0])
    else $error("Relay on while disabled");
  a_byp_relay: assert property (relay_opt_in[3:0] == sioflg_pkg::RO_BYP
    |=> relay_out[0] == $past(bypass_closed_in))
    else $error("Bypass relay wrong");
  a_byp_inverted: assert property (relay_opt_in[7:4] == sioflg_pkg::RO_BYP_N
    |=> relay_out[1] != $past(bypass_closed_in))
    else $error("Inverted bypass relay wrong");
  a_ener_relay: assert property (s_ener_sel |=> relay_out[0] == $past(ener))
    else $error("Energized relay wrong");
  a_full_scale: assert property (in_func_in[15:12] == sioflg_pkg::FN_ANALOG &&
    analog_code_in == 12'hFFF |=> analog_pct_out == 7'h64)
    else $error("Full scale not 100 percent");
  a_action_off: assert property (analog_action_in == sioflg_pkg::ACT_OFF
    |=> !(analog_trip_out || analog_warn_out))
    else $error("Analog alarm while disabled");
endmodule
bind sioflg_core sioflg_asserts u_chk (
  .mclk_in(mclk_in), .arst_n_in(arst_n_in), .bypass_closed_in(bypass_closed_in),
  .ramp_active_in(ramp_active_in), .running_in(running_in), .soft_stop_in(soft_stop_in),
  .pump_stop_in(pump_stop_in), .relay_opt_in(relay_opt_in), .analog_code_in(analog_code_in),
  .in_func_in(in_func_in),
  .analog_action_in(analog_action_in), .ext_trip_out(ext_trip_out),
  .ext_warn_out(ext_warn_out), .motor_power_kill_out(motor_power_kill_out),
  .overload_enable_out(overload_enable_out), .analog_trip_out(analog_trip_out),
  .analog_warn_out(analog_warn_out), .analog_pct_out(analog_pct_out),
  .fault_any_out(fault_any_out), .warn_any_out(warn_any_out), .relay_out(relay_out));

// ---- sioflg_field.sv ----
// Field model: control switches with chatter and a PLC reading the relays
`timescale 1ns/10ps
module sioflg_field #(
  parameter int DEB = 8
) (
  input  wire logic       mclk_in,
  input  wire logic [3:0] lvl_in,
  input  wire logic [3:0] bnc_in,
  input  wire logic [1:0] relay_in,
  output logic      [3:0] ctl_out,
  output logic      [1:0] plc_out
);
  int cnt[2];                        // Cycles a new relay state has held
  // Chattering contacts flip each cycle, steady ones follow the command
  initial begin
    ctl_out = 4'h0;
    forever @(negedge mclk_in) ctl_out <= (~ctl_out & bnc_in) | (lvl_in & ~bnc_in);
  end
  // Accept a relay change only once it has persisted DEB cycles
  initial begin
    plc_out = 2'h0;
    forever @(posedge mclk_in) begin
      for (int r = 0; r < 2; r++) begin
        cnt[r] <= (relay_in[r] === plc_out[r]) ? 0 : cnt[r] + 1;
        if (cnt[r] == DEB) plc_out[r] <= relay_in[r];
      end
    end
  end
endmodule

// ---- test_starter_io_function_logic.sv ----
// Self-checking bench for the control-input and status-relay block
`timescale 1ns/10ps
module test_starter_io_function_logic;
  localparam int FC = 4;                  // Shortened filter count
  logic        mclk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [3:0]  lvl = '0, bnc = '0, mst = '0, ctl_in;
  logic [15:0] fn = '0;                   // Function codes
  logic [11:0] acode = '0;                // Analog current code
  logic [7:0]  ropt = '0;                 // Relay options
  logic [63:0] fa = '0, wa = '0, pe = '1; // Per-code fault, warning, enable
  logic [1:0]  aact = '0, rly, hit, plc;
  logic        arng = 0, start = 0, byp = 0, of = 0, ow = 0;
  logic        ainh, etrip, ewarn, kill, olen, atrip, awarn, fany, wany;
  logic [6:0]  pct;
  logic [43:0] q[$], nt;                  // Expected notes: masks and values
  logic [7:0]  ct[4] = '{8'hC7, 8'h88, 8'h64, 8'h77}; // Custom list cases
  int          errors = 0, num_checks = 0, cyc = 0;
  event        smp;                       // Result ready for the monitor
  wire  [19:0] obs = {pct, ainh, etrip, ewarn, kill, olen, atrip, awarn, fany, wany, rly, hit};
  always #4 mclk_in = ~mclk_in;
  sioflg_field #(.DEB(8)) u_field (.mclk_in(mclk_in), .lvl_in(lvl), .bnc_in(bnc),
    .relay_in(rly), .ctl_out(ctl_in), .plc_out(plc));
  sioflg_core #(.FILT_CY(FC)) DUT (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .ctl_in(ctl_in), .in_func_in(fn), .analog_code_in(acode), .analog_range_in(arng),
    .analog_high_in(7'h32), .analog_low_in(7'h0A), .analog_action_in(aact),
    .start_cmd_in(start), .ramp_active_in(mst[0]), .running_in(mst[1]),
    .soft_stop_in(mst[2]), .pump_stop_in(mst[3]), .bypass_closed_in(byp),
    .other_fault_in(of), .other_warn_in(ow), .relay_opt_in(ropt),
    .custom_code_in({2{6'h07, 6'h06, 6'h05}}), .custom_is_fault_in(6'h2D),
    .fault_active_in(fa), .warn_active_in(wa), .prot_enable_in(pe),
    .alarm_inhibit_out(ainh), .ext_trip_out(etrip), .ext_warn_out(ewarn),
    .motor_power_kill_out(kill), .overload_enable_out(olen), .analog_trip_out(atrip),
    .analog_warn_out(awarn), .analog_pct_out(pct), .fault_any_out(fany),
    .warn_any_out(wany), .relay_out(rly), .custom_is_fault_hit_out(hit));
  // Print counts and verdict, then stop
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      final_report();
    end
  end
  // Monitor: compare settled outputs against the oldest note
  always @(smp) begin
    nt = q.pop_front();
    num_checks++;
    if ((obs & nt[43:24]) !== nt[23:4]) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, obs & nt[43:24], nt[23:4]);
    end
    if ((plc & nt[3:2]) !== nt[1:0]) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, plc & nt[3:2], nt[1:0]);
    end
  end
  task automatic w(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  // Note an expectation and hand it to the monitor
  task automatic chk(input logic [19:0] m, input logic [19:0] e,
                     input logic [1:0] pm = 2'h0, input logic [1:0] pv = 2'h0);
    q.push_back({m, e, pm, pv});
    -> smp;
    @(negedge mclk_in);
  endtask
  // Expected relay level: pairs of plain and inverted options
  function automatic logic rx(input logic [3:0] o, input logic f, w, b, e);
    logic [3:0] c;
    c = {w, e, b, f};
    if (o == 4'h0 || o > 4'h8) return 1'b0;
    return c[(o - 4'h1) >> 1] ^ ~o[0];
  endfunction
  initial begin
    void'($urandom(32'h3F42));
    w(5);
    chk(20'hFFFFF, 20'h00100);
    arst_n_in = 1'b1;
    $display("reset test done");
    fn = 16'h0798;
    lvl = 4'hF;
    w(12);
    chk(20'h01E30, 20'h0);
    lvl = 4'h0;
    bnc = 4'h7;
    w(12);
    chk(20'h01E30, 20'h0);
    bnc = 4'h0;
    w(12);
    chk(20'h01E30, 20'h01E30);
    $display("input function test done");
    fn = 16'h0;
    for (int o = 0; o < 9; o++) begin
      {of, ow, byp, mst} = 7'($urandom);
      ropt = {4'(8 - o), 4'(o)};
      w(3);
      chk(20'h0000C, {16'h0, rx(4'(8 - o), of, ow, byp, |mst), rx(4'(o), of, ow, byp, |mst), 2'b00});
    end
    $display("relay option test done");
    ropt = 8'hA9;
    for (int i = 0; i < 4; i++) begin
      {fa[5], pe[5], wa[6], fa[7]} = ct[i][7:4];
      w(3);
      chk(20'h0000F, {16'h0, ct[i][3:0]});
    end
    w(9);
    chk(20'h0000C, 20'h00004, 2'h3, 2'h1);
    {wa[6], fa[7]} = 2'b00;
    w(3);
    chk(20'h0000C, 20'h00008, 2'h3, 2'h1);
    {wa[6], fa[7]} = 2'b11;
    $display("custom relay test done");
    {byp, start, lvl} = 6'h8;
    fn = 16'hA000;
    w(12);
    start = 1'b1;
    w(3);
    chk(20'h00100, 20'h0);
    byp = 1'b1;
    w(3);
    chk(20'h00100, 20'h00100);
    {byp, start, lvl} = 6'h0;
    w(12);
    start = 1'b1;
    w(3);
    chk(20'h00100, 20'h00100);
    $display("overload inhibit test done");
    fn = 16'hB000;
    for (int r = 0; r < 2; r++) begin
      arng = r[0];
      acode = 12'h333 + 12'($urandom % 3277);
      w(3);
      chk(20'hFE000, {r ? 7'((acode - 12'h333) * 100 / 3276) : 7'(acode * 100 / 4095), 13'h0});
    end
    acode = 12'hFFF;
    for (int a = 0; a < 3; a++) begin
      aact = 2'(a);
      w(3);
      chk(20'h000C0, {12'h0, a == 1, a == 2, 6'h0});
    end
    acode = 12'h000;
    w(3);
    chk(20'h000C0, 20'h00040);
    $display("analog test done");
    final_report();
  end
endmodule
